// file: dpm_consts.svh
// Constants for the dual port pin function mux: register indices, field positions,
// reset values and implemented-bit masks.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// ==========================================================================
// Register indices (byte address on the bus is four times the index)
// ==========================================================================
`define DPM_IDX_PC_DATA      8'h23
`define DPM_IDX_PC_DIR       8'h26
`define DPM_IDX_PC_FUNC      8'h27
`define DPM_IDX_PC_PULL      8'h28
`define DPM_IDX_PD_DATA      8'h29
`define DPM_IDX_PD_FUNC      8'h2a
`define DPM_IDX_PD_DIR       8'h2b
`define DPM_IDX_PD_PULLUP    8'h2c
`define DPM_IDX_PC_OSC       8'h30

// ==========================================================================
// Port C pull, drain and oscillator control fields
// ==========================================================================
`define DPM_PC_PIN3_PULLUP   0
`define DPM_PC_PIN4_RES_EN   1
`define DPM_PC_PIN5_RES_EN   2
`define DPM_PC_PIN4_PULL_DIR 3
`define DPM_PC_PIN5_PULL_DIR 4
`define DPM_PC_OPEN_DRAIN    5
`define DPM_PC_OSC_EN        0

// ==========================================================================
// Implemented bits and reset values
// ==========================================================================
`define DPM_PC_MASK          8'hf8
`define DPM_PC_FUNC_MASK     8'h28
`define DPM_PC_PULL_MASK     8'h3f
`define DPM_PD_MASK          8'hdf
`define DPM_PC_LATCH_RST     8'hf8
`define DPM_PC_DIR_RST       8'h00
`define DPM_PC_FUNC_RST      8'h00
`define DPM_PC_PULL_RST      8'h00
`define DPM_PD_LATCH_RST     8'hdf
`define DPM_PD_DIR_RST       8'h00
`define DPM_PD_FUNC_RST      8'h00
`define DPM_PD_PULLUP_RST    8'h1f

`endif

// file: dpm_pkg.sv
// Types shared by the dual port pin function mux design files.
// Assumes nothing beyond a SystemVerilog compiler.
package dpm_pkg;

   // ========================================================================
   // Pad bundle: per-pin output, output enable and pull controls
   // ========================================================================
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
   } dpm_pad_t;

   // ========================================================================
   // Display port alternate function sources
   // ========================================================================
   typedef struct packed {
      logic lcd_shift_clock_strobe;
      logic lcd_latch_pulse;
      logic lcd_frame_signal;
      logic lcd_enable_strobe;
      logic display_off_out;
      logic rtc_alarm_out;
      logic melody_alarm_out;
   } dpm_disp_fn_t;

endpackage : dpm_pkg

// file: dpm_pin_sync.sv
// Two-flop synchroniser for an eight-bit group of pad input levels.
// Assumes pads change with no relation to pclk.
`timescale 1ns/1ps
`default_nettype none

module dpm_pin_sync (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] pin_async,
   output logic      [7:0] pin_sync
);

   logic [7:0] meta_q;
   logic [7:0] sync_q;

   // ========================================================================
   // One synchroniser per pin; the first stage feeds only the second
   // ========================================================================
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= pin_async[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign pin_sync = sync_q;

endmodule : dpm_pin_sync

`default_nettype wire

// file: dpm_port_mux.sv
// Two general-purpose ports with pin function muxing behind an APB slave:
// a 5-bit serial-capable port (pins 3..7) and a 7-bit display port (pins 0..4, 6, 7).
// Assumes pads resolve out/oe/pull externally and serial, LCD and alarm sources run on pclk.
//
// Notes on behaviour
// - Serial port reset: all five pins inputs, output latch all ones.
// - Function bit one hands pin to serial channel, zero keeps port pin.
// - Pin 3 transmit output inverted when its latch bit is one.
// - Pin 3 driver is push-pull or open-drain by its drain select bit.
// - Pin 3 pull-up enabled by writing one; reset leaves input without pull-up.
// - Pin 4 receive signal inverted when its latch bit is one.
// - Pin 4 resistor enable attaches pull; separate bit picks up or down.
// - Pin 5 clear-to-send and serial clock inverted when its latch bit is one.
// - Pin 5 resistor enable attaches pull; separate bit picks up or down.
// - Receiver always sees pin 4, even while it is a general input.
// - Pins 6 and 7 may be handed to the low-frequency oscillator.
// - Display port reset: pins 0-4 inputs with pull-up, pins 6-7 without.
// - Display port output latch resets to all ones.
// - Display pins 0-4 and 7 carry LCD strobes, display-off, melody.
// - Display pin 6 carries alarm when latch bit one, else melody.
`timescale 1ns/1ps
`default_nettype none
`include "dpm_consts.svh"

module dpm_port_mux
   import dpm_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [7:0]   pc_pin_in,
   output dpm_pad_t          pc_pad,
   input  wire logic [7:0]   pd_pin_in,
   output dpm_pad_t          pd_pad,
   input  wire logic         serial_transmit_out,
   input  wire logic         serial_clock_out,
   output logic              serial_receive_in,
   output logic              clear_to_send_in,
   output logic              serial_clock_in,
   input  wire dpm_disp_fn_t disp_fn,
   output logic              osc_handover
);

   // ========================================================================
   // Register state
   // ========================================================================
   logic [7:0] pc_latch_q;
   logic [7:0] pc_dir_q;
   logic [7:0] pc_func_q;
   logic [7:0] pc_pull_q;
   logic       pc_osc_q;
   logic [7:0] pd_latch_q;
   logic [7:0] pd_dir_q;
   logic [7:0] pd_func_q;
   logic [7:0] pd_pullup_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   logic [7:0] pc_sync;
   logic [7:0] pd_sync;

   dpm_pad_t   pc_pad_d;
   dpm_pad_t   pc_pad_q;
   dpm_pad_t   pd_pad_d;
   dpm_pad_t   pd_pad_q;
   logic       rx_q;
   logic       cts_q;
   logic       sclk_in_q;

   // ========================================================================
   // Pad input synchronisers
   // ========================================================================
   dpm_pin_sync u_pc_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (pc_pin_in),
      .pin_sync  (pc_sync)
   );

   dpm_pin_sync u_pd_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (pd_pin_in),
      .pin_sync  (pd_sync)
   );

   // ========================================================================
   // APB decode
   // ========================================================================
   logic       setup_ph;
   logic       wr_en;
   logic [5:0] word_idx;
   logic       aligned;
   logic       hit_pc_data;
   logic       hit_pc_dir;
   logic       hit_pc_func;
   logic       hit_pc_pull;
   logic       hit_pc_osc;
   logic       hit_pd_data;
   logic       hit_pd_func;
   logic       hit_pd_dir;
   logic       hit_pd_pullup;
   logic       hit_any;
   logic [7:0] wbyte;

   assign setup_ph      = psel && !penable;
   assign word_idx      = paddr[7:2];
   assign aligned       = (paddr[1:0] == 2'h0);
   assign hit_pc_data   = aligned && ({2'b00, word_idx} == `DPM_IDX_PC_DATA);
   assign hit_pc_dir    = aligned && ({2'b00, word_idx} == `DPM_IDX_PC_DIR);
   assign hit_pc_func   = aligned && ({2'b00, word_idx} == `DPM_IDX_PC_FUNC);
   assign hit_pc_pull   = aligned && ({2'b00, word_idx} == `DPM_IDX_PC_PULL);
   assign hit_pc_osc    = aligned && ({2'b00, word_idx} == `DPM_IDX_PC_OSC);
   assign hit_pd_data   = aligned && ({2'b00, word_idx} == `DPM_IDX_PD_DATA);
   assign hit_pd_func   = aligned && ({2'b00, word_idx} == `DPM_IDX_PD_FUNC);
   assign hit_pd_dir    = aligned && ({2'b00, word_idx} == `DPM_IDX_PD_DIR);
   assign hit_pd_pullup = aligned && ({2'b00, word_idx} == `DPM_IDX_PD_PULLUP);
   assign hit_any       = hit_pc_data || hit_pc_dir || hit_pc_func || hit_pc_pull || hit_pc_osc
                          || hit_pd_data || hit_pd_func || hit_pd_dir || hit_pd_pullup;
   // Only the low byte lane carries register data
   assign wr_en         = psel && penable && pwrite && pstrb[0];
   assign wbyte         = pwdata[7:0];

   // Zero-wait slave; read data and error are sampled in the setup phase
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // ========================================================================
   // Read path
   // ========================================================================
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_pc_data) begin
         rd_byte = pc_sync & `DPM_PC_MASK;
      end else if (hit_pd_data) begin
         rd_byte = pd_sync & `DPM_PD_MASK;
      end
      // Control registers are write-only and read back as zero
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_q <= !hit_any;
      end
   end

   // ========================================================================
   // Port C registers
   // ========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_latch_q <= `DPM_PC_LATCH_RST;
      end else if (wr_en && hit_pc_data) begin
         pc_latch_q <= wbyte & `DPM_PC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_dir_q <= `DPM_PC_DIR_RST;
      end else if (wr_en && hit_pc_dir) begin
         pc_dir_q <= wbyte & `DPM_PC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_func_q <= `DPM_PC_FUNC_RST;
      end else if (wr_en && hit_pc_func) begin
         pc_func_q <= wbyte & `DPM_PC_FUNC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_pull_q <= `DPM_PC_PULL_RST;
      end else if (wr_en && hit_pc_pull) begin
         pc_pull_q <= wbyte & `DPM_PC_PULL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_osc_q <= 1'b0;
      end else if (wr_en && hit_pc_osc) begin
         pc_osc_q <= wbyte[`DPM_PC_OSC_EN];
      end
   end

   // ========================================================================
   // Port D registers
   // ========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_latch_q <= `DPM_PD_LATCH_RST;
      end else if (wr_en && hit_pd_data) begin
         pd_latch_q <= wbyte & `DPM_PD_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_dir_q <= `DPM_PD_DIR_RST;
      end else if (wr_en && hit_pd_dir) begin
         pd_dir_q <= wbyte & `DPM_PD_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_func_q <= `DPM_PD_FUNC_RST;
      end else if (wr_en && hit_pd_func) begin
         pd_func_q <= wbyte & `DPM_PD_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_pullup_q <= `DPM_PD_PULLUP_RST;
      end else if (wr_en && hit_pd_pullup) begin
         // Bit 5 has no pin; masking keeps a stray one from reaching a pad
         pd_pullup_q <= wbyte & `DPM_PD_MASK;
      end
   end

   // ========================================================================
   // Port C pad mux
   // ========================================================================
   logic pin3_value;
   logic pin5_value;
   logic open_drain;

   always_comb begin
      pc_pad_d   = '0;
      open_drain = pc_pull_q[`DPM_PC_OPEN_DRAIN];
      // Transmit output with optional inversion by the latch bit
      pin3_value = pc_func_q[3] ? (serial_transmit_out ^ pc_latch_q[3]) : pc_latch_q[3];
      pin5_value = pc_func_q[5] ? (serial_clock_out ^ pc_latch_q[5]) : pc_latch_q[5];

      pc_pad_d.out[3] = pin3_value;
      // Open drain only pulls low; a one releases the pad
      pc_pad_d.oe[3]  = pc_dir_q[3] && !(open_drain && pin3_value);
      pc_pad_d.pull_up[3] = pc_pull_q[`DPM_PC_PIN3_PULLUP];

      pc_pad_d.out[4] = pc_latch_q[4];
      pc_pad_d.oe[4]  = pc_dir_q[4];
      pc_pad_d.pull_up[4]   = pc_pull_q[`DPM_PC_PIN4_RES_EN] && !pc_pull_q[`DPM_PC_PIN4_PULL_DIR];
      pc_pad_d.pull_down[4] = pc_pull_q[`DPM_PC_PIN4_RES_EN] && pc_pull_q[`DPM_PC_PIN4_PULL_DIR];

      pc_pad_d.out[5] = pin5_value;
      pc_pad_d.oe[5]  = pc_dir_q[5];
      pc_pad_d.pull_up[5]   = pc_pull_q[`DPM_PC_PIN5_RES_EN] && !pc_pull_q[`DPM_PC_PIN5_PULL_DIR];
      pc_pad_d.pull_down[5] = pc_pull_q[`DPM_PC_PIN5_RES_EN] && pc_pull_q[`DPM_PC_PIN5_PULL_DIR];

      // Oscillator owns pins 6 and 7 while handed over: no drive at all
      pc_pad_d.out[6] = pc_latch_q[6];
      pc_pad_d.out[7] = pc_latch_q[7];
      pc_pad_d.oe[6]  = pc_dir_q[6] && !pc_osc_q;
      pc_pad_d.oe[7]  = pc_dir_q[7] && !pc_osc_q;
   end

   // ========================================================================
   // Port D pad mux
   // ========================================================================
   logic [7:0] pd_fn_val;

   always_comb begin
      pd_pad_d     = '0;
      pd_fn_val    = 8'h00;
      pd_fn_val[0] = disp_fn.lcd_shift_clock_strobe;
      pd_fn_val[1] = disp_fn.lcd_latch_pulse;
      pd_fn_val[2] = disp_fn.lcd_frame_signal;
      pd_fn_val[3] = disp_fn.lcd_enable_strobe;
      pd_fn_val[4] = disp_fn.display_off_out;
      pd_fn_val[6] = pd_latch_q[6] ? disp_fn.rtc_alarm_out : disp_fn.melody_alarm_out;
      pd_fn_val[7] = disp_fn.melody_alarm_out;
      pd_pad_d.out     = ((pd_func_q & pd_fn_val) | (~pd_func_q & pd_latch_q)) & `DPM_PD_MASK;
      pd_pad_d.oe      = pd_dir_q & `DPM_PD_MASK;
      pd_pad_d.pull_up = pd_pullup_q & `DPM_PD_MASK;
   end

   // ========================================================================
   // Registered pad outputs and serial inputs
   // ========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_pad_q <= '0;
         pd_pad_q <= '0;
      end else begin
         pc_pad_q <= pc_pad_d;
         pd_pad_q <= pd_pad_d;
      end
   end

   // Receive path ignores function and direction, so it sees pin 4 always
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q      <= 1'b0;
         cts_q     <= 1'b0;
         sclk_in_q <= 1'b0;
      end else begin
         rx_q      <= pc_sync[4] ^ pc_latch_q[4];
         cts_q     <= pc_sync[5] ^ pc_latch_q[5];
         sclk_in_q <= pc_sync[5] ^ pc_latch_q[5];
      end
   end

   assign pc_pad            = pc_pad_q;
   assign pd_pad            = pd_pad_q;
   assign serial_receive_in = rx_q;
   assign clear_to_send_in  = cts_q;
   assign serial_clock_in   = sclk_in_q;
   assign osc_handover      = pc_osc_q;

endmodule : dpm_port_mux

`default_nettype wire

// file: dpm_port_mux_asserts.sv
// Checker for dpm_port_mux: APB decode, pad drive and pin sync paths.
// Assumes it is bound to the top; register state is rebuilt from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "dpm_consts.svh"
module dpm_port_mux_asserts
   import dpm_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic [7:0]   paddr,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [31:0]  pwdata,
   input wire logic [3:0]   pstrb,
   input wire logic [31:0]  prdata,
   input wire logic         pslverr,
   input wire logic [7:0]   pc_pin_in,
   input wire dpm_pad_t     pc_pad,
   input wire dpm_pad_t     pd_pad,
   input wire logic         serial_transmit_out,
   input wire logic         serial_receive_in,
   input wire logic         clear_to_send_in,
   input wire dpm_disp_fn_t disp_fn,
   input wire logic         osc_handover
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====
   // Register shadow, indexed by word index
   logic [7:0] sh_q [64];
   logic [7:0] dfn;
   logic [5:0] ix;
   logic       map;
   logic       wo;
   logic       tx_v;
   assign ix = paddr[7:2];
   assign wo = ix inside {6'h26, 6'h27, 6'h28, 6'h2a, 6'h2b, 6'h2c};
   assign map = paddr[1:0] == 2'b00 && (wo || ix inside {6'h23, 6'h29, 6'h30});
   assign tx_v = sh_q[6'h27][3] ? serial_transmit_out ^ sh_q[6'h23][3] : sh_q[6'h23][3];
   assign dfn = {disp_fn.melody_alarm_out, sh_q[6'h29][6] ? disp_fn.rtc_alarm_out : disp_fn.melody_alarm_out,
                 1'b0, disp_fn.display_off_out, disp_fn.lcd_enable_strobe, disp_fn.lcd_frame_signal,
                 disp_fn.lcd_latch_pulse, disp_fn.lcd_shift_clock_strobe};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= '{default: 8'h00};
         sh_q[6'h23] <= `DPM_PC_LATCH_RST;
         sh_q[6'h29] <= `DPM_PD_LATCH_RST;
         sh_q[6'h2c] <= `DPM_PD_PULLUP_RST;
      end else if (psel && penable && pwrite && pstrb[0] && map) begin
         sh_q[ix] <= pwdata[7:0];
      end
   end
   sequence rd_at(logic c);
      psel && penable && !pwrite && c;
   endsequence
   // ====
   // Pads lag the registers by one edge; sync paths by three
   rx_invert_a: assert property ($past(presetn, 3) |->
      serial_receive_in == ($past(pc_pin_in[4], 3) ^ $past(sh_q[6'h23][4]))) else $error("receive level wrong");
   cts_invert_a: assert property ($past(presetn, 3) |->
      clear_to_send_in == ($past(pc_pin_in[5], 3) ^ $past(sh_q[6'h23][5]))) else $error("cts level wrong");
   pc_drive_a: assert property ($past(presetn, 2) |-> pc_pad.oe[7:3] ==
      $past({sh_q[6'h26][7:6] & ~{2{sh_q[6'h30][0]}}, sh_q[6'h26][5:4], sh_q[6'h26][3] & ~(sh_q[6'h28][5] & tx_v)}))
      else $error("port C enables wrong");
   tx_out_a: assert property ($past(presetn, 2) && pc_pad.oe[3] |-> pc_pad.out[3] == $past(tx_v))
      else $error("pin 3 output wrong");
   pc_pull_a: assert property ($past(presetn, 2) |->
      {pc_pad.pull_up[5:3], pc_pad.pull_down[5:3]} == $past({sh_q[6'h28][2] & ~sh_q[6'h28][4],
      sh_q[6'h28][1] & ~sh_q[6'h28][3], sh_q[6'h28][0], sh_q[6'h28][2] & sh_q[6'h28][4],
      sh_q[6'h28][1] & sh_q[6'h28][3], 1'b0})) else $error("port C pulls wrong");
   pd_drive_a: assert property ($past(presetn, 2) |-> pd_pad.oe == $past(sh_q[6'h2b] & 8'hdf) &&
      (pd_pad.out & pd_pad.oe) == $past((sh_q[6'h2a] & dfn | ~sh_q[6'h2a] & sh_q[6'h29]) & sh_q[6'h2b] & 8'hdf))
      else $error("port D drive wrong");
   pd_pull_a: assert property ($past(presetn, 2) |-> pd_pad.pull_up == $past(sh_q[6'h2c] & 8'hdf))
      else $error("port D pull-up wrong");
   osc_hand_a: assert property ($past(presetn, 2) |-> osc_handover == sh_q[6'h30][0])
      else $error("oscillator handover wrong");
   bad_addr_a: assert property (psel && penable |-> pslverr == !map)
      else $error("slave error wrong");
   wo_read_a: assert property (rd_at(map && wo) |-> prdata == 32'h0)
      else $error("write-only register read nonzero");
   pin_read_a: assert property (rd_at(ix == 6'h23 && $past(presetn, 3)) |->
      prdata == {24'h0, $past(pc_pin_in, 3) & 8'hf8}) else $error("port C read wrong");
endmodule : dpm_port_mux_asserts
`default_nettype wire

// file: dpm_pad_model.sv
// Pad model: resolves each pad from the mux drive, an outside driver and pulls.
// Assumes the bench sets outside levels; a released pad with no pull wanders.
`timescale 1ns/1ps
`default_nettype none
module dpm_pad_model
   import dpm_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire dpm_pad_t   pad,
   input  wire logic [7:0] ext_lvl,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pin
);
   logic [7:0] wander_q;
   // Floating pads change every cycle so no settled value passes by luck
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wander_q <= 8'h55;
      else wander_q <= ~wander_q;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad.oe[i]) pin[i] = pad.out[i];
         else if (ext_en[i]) pin[i] = ext_lvl[i];
         else if (pad.pull_up[i]) pin[i] = 1'b1;
         else if (pad.pull_down[i]) pin[i] = 1'b0;
         else pin[i] = wander_q[i];
      end
   end
endmodule : dpm_pad_model
`default_nettype wire

// file: dual_port_pin_function_mux_tb_top.sv
// Bench for dpm_port_mux: APB traffic, pad levels, serial and display functions.
// Assumes the design, its checker and the pad model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dual_port_pin_function_mux_tb_top
   import dpm_pkg::*;
;
   typedef struct packed {logic [7:0] wi, wd, ri, ex;} dpm_row_t;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, tx, rx, cts, sck, osc;
   logic [7:0]   paddr, pc_pin, pd_pin, ext_c, en_c, ext_d;
   logic [31:0]  pwdata, prdata, rd;
   logic [3:0]   pstrb;
   dpm_pad_t     pc_pad, pd_pad;
   dpm_disp_fn_t disp;
   int           err_total, checks_done;
   dpm_row_t     rows [6] = '{'{8'h26, 8'h08, 8'h26, 8'h00}, '{8'h23, 8'h00, 8'h23, 8'hf0},
      '{8'h23, 8'h08, 8'h23, 8'hf8}, '{8'h2b, 8'h01, 8'h29, 8'h01}, '{8'h29, 8'h00, 8'h29, 8'h00},
      '{8'h2a, 8'h01, 8'h29, 8'h01}};
   dpm_port_mux i_dpm_port_mux (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pc_pin_in(pc_pin), .pc_pad(pc_pad), .pd_pin_in(pd_pin), .pd_pad(pd_pad), .serial_transmit_out(tx),
      .serial_clock_out(tx), .serial_receive_in(rx), .clear_to_send_in(cts), .serial_clock_in(sck),
      .disp_fn(disp), .osc_handover(osc));
   dpm_pad_model i_pc_pads (.pclk(pclk), .presetn(presetn), .pad(pc_pad), .ext_lvl(ext_c), .ext_en(en_c),
      .pin(pc_pin));
   dpm_pad_model i_pd_pads (.pclk(pclk), .presetn(presetn), .pad(pd_pad), .ext_lvl(ext_d), .ext_en(8'hff),
      .pin(pd_pin));
   // ====
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx[5:0], 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // The wait for the answer ends on the first edge that sees pready at one
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Pads settle one edge after a write, then pass two sync flops
   task automatic peek(input logic [7:0] idx, input logic [31:0] exp);
      repeat (4) @(posedge pclk);
      apb(idx, 1'b0, 8'h00);
      check(rd, exp);
   endtask : peek
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic results;
      $display("comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // ====
   // Clock, watchdog and tests
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end
   initial begin
      {presetn, psel, penable, pwrite, tx, paddr, pwdata} = '0;
      pstrb = 4'hf;
      {ext_c, en_c, ext_d} = {8'hff, 8'hff, 8'h00};
      disp = 7'h40;
      err_total = 0;
      checks_done = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].wi, 1'b1, rows[i].wd);
         peek(rows[i].ri, {24'h0, rows[i].ex});
      end
      done("table");
      tx <= 1'b1;
      apb(8'h26, 1'b1, 8'h28);
      apb(8'h27, 1'b1, 8'h28);
      for (int i = 0; i < 2; i++) begin
         apb(8'h23, 1'b1, i ? 8'h00 : 8'h28);
         peek(8'h23, i ? 32'hf8 : 32'hd0);
      end
      done("transmit");
      apb(8'h26, 1'b1, 8'h08);
      apb(8'h27, 1'b1, 8'h00);
      en_c <= 8'hf7;
      apb(8'h28, 1'b1, 8'h21);
      for (int i = 0; i < 2; i++) begin
         apb(8'h23, 1'b1, i ? 8'h08 : 8'h00);
         peek(8'h23, i ? 32'hf8 : 32'hf0);
      end
      done("open drain");
      en_c <= 8'hcf;
      for (int i = 0; i < 2; i++) begin
         apb(8'h28, 1'b1, i ? 8'h16 : 8'h0e);
         peek(8'h23, i ? 32'hd8 : 32'he8);
      end
      done("pulls");
      {en_c, ext_c} <= {8'hff, 8'hef};
      for (int i = 0; i < 2; i++) begin
         apb(8'h23, 1'b1, i ? 8'h00 : 8'h30);
         repeat (4) @(posedge pclk);
         check({29'h0, rx, cts, sck}, i ? 32'h3 : 32'h4);
      end
      done("serial inputs");
      disp <= 7'h02;
      apb(8'h2b, 1'b1, 8'h40);
      apb(8'h2a, 1'b1, 8'h40);
      for (int i = 0; i < 2; i++) begin
         apb(8'h29, 1'b1, i ? 8'h00 : 8'h40);
         peek(8'h29, i ? 32'h00 : 32'h40);
      end
      done("alarm pin");
      apb(8'h26, 1'b1, 8'hc0);
      apb(8'h30, 1'b1, 8'h01);
      apb(8'h2c, 1'b1, 8'hff);
      repeat (3) @(posedge pclk);
      check({29'h0, osc, pc_pad.oe[7:6]}, 32'h4);
      check({24'h0, pd_pad.pull_up}, 32'hdf);
      apb(8'h01, 1'b0, 8'h00);
      check({31'h0, perr}, 32'h1);
      done("handover and decode");
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      ext_c <= 8'h00;
      repeat (3) @(posedge pclk);
      check({pc_pad.oe, pc_pad.pull_up, pd_pad.oe, pd_pad.pull_up}, 32'h1f);
      apb(8'h26, 1'b1, 8'hf8);
      peek(8'h23, 32'hf8);
      apb(8'h2b, 1'b1, 8'hdf);
      peek(8'h29, 32'hdf);
      done("reset");
      results();
   end
endmodule : dual_port_pin_function_mux_tb_top
bind dpm_port_mux dpm_port_mux_asserts i_dpm_port_mux_asserts (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pslverr(pslverr), .pc_pin_in(pc_pin_in), .pc_pad(pc_pad), .pd_pad(pd_pad),
   .serial_transmit_out(serial_transmit_out), .serial_receive_in(serial_receive_in),
   .clear_to_send_in(clear_to_send_in), .disp_fn(disp_fn), .osc_handover(osc_handover));
`default_nettype wire
